// ==== fws_ctrl.sv ====
// Purpose: host-side sequencer for byte program and block erase of a parallel flash
// Assumes: flash pins synchronous to core_clk, one device on the pins
// Notes: every program or erase not aborted by powerdown ends with a read-array write
`timescale 1ns/10ps
`include "fws_params.svh"
module fws_ctrl #(
	parameter int STROBE_CYC = `FWS_STROBE_CYC,
	parameter int RFALL_CYC = `FWS_RFALL_CYC,
	parameter int WAKE_CYC = `FWS_WAKE_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// user side
	input wire logic cmd_valid,
	input fws_pkg::fws_req_s cmd_req,
	output logic cmd_ready_r,
	output logic done_r,
	output logic abort_r,
	output logic [7:0] status_r,
	output logic [2:0] err_acc_r,
	output logic [7:0] rd_data_r,
	input wire logic pd_req,
	// flash pins
	output fws_pkg::fws_pins_s pins_r,
	input wire logic [7:0] dq_in,
	input wire logic ready_busy_in,
	output logic pwd_n_r
);
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_CMD1 = 4'h1,
		S_CMD2 = 4'h2,
		S_WAIT = 4'h3,
		S_POLL = 4'h4,
		S_CHECK = 4'h5,
		S_CLR = 4'h6,
		S_ARRAY = 4'h7,
		S_READ = 4'h8,
		S_PD = 4'h9,
		S_WAKE = 4'hA
	} fws_state_e;

	fws_state_e state_r;
	fws_pkg::fws_req_s op_r;
	logic pend_r;
	logic req_valid_r;
	logic req_write_r;
	logic [7:0] req_data_r;
	logic [7:0] cnt_r;
	logic bus_idle;
	logic bus_done;
	logic [7:0] bus_rd;

	// write flag and data byte of the cycle a state issues
	function automatic logic [8:0] cycle_of(input fws_state_e st, input fws_pkg::fws_req_s r);
		logic [8:0] v;
		v = {1'b0, 8'h00};
		unique case (st)
			S_CMD1: v = {1'b1, (r.op == fws_pkg::OP_ERASE) ? `FWS_CMD_ERASE : `FWS_CMD_PROG};
			S_CMD2: v = {1'b1, (r.op == fws_pkg::OP_ERASE) ? `FWS_CMD_CONFIRM : r.data};
			S_CLR: v = {1'b1, `FWS_CMD_CLEAR};
			S_ARRAY: v = {1'b1, `FWS_CMD_ARRAY};
			default: v = {1'b0, 8'h00};
		endcase
		return v;
	endfunction

	wire issue_st = (state_r == S_CMD1) || (state_r == S_CMD2) || (state_r == S_POLL) ||
		(state_r == S_CLR) || (state_r == S_ARRAY) || (state_r == S_READ);
	wire [8:0] cyc_w = cycle_of(state_r, op_r);
	wire issue_go = issue_st && !pend_r && bus_idle && !req_valid_r;
	wire [7:0] stat_w = bus_rd & `FWS_STAT_MASK;
	wire stat_ready = stat_w[`FWS_SR_READY];
	wire [2:0] stat_err = {stat_w[`FWS_SR_ERASE_FAIL], stat_w[`FWS_SR_PROG_FAIL], stat_w[`FWS_SR_SUPPLY_LOW]};
	wire is_prog_erase = (op_r.op == fws_pkg::OP_PROGRAM) || (op_r.op == fws_pkg::OP_ERASE);
	wire pd_hit = pd_req && (state_r != S_PD) && (state_r != S_WAKE);
	wire bus_abort = pd_req || !pwd_n_r;

	fws_bus_cycle #(
		.STROBE_CYC(STROBE_CYC)
	) u_bus (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.req_valid(req_valid_r),
		.req_write(req_write_r),
		.req_addr(op_r.addr),
		.req_data(req_data_r),
		.abort(bus_abort),
		.idle_r(bus_idle),
		.done_r(bus_done),
		.rd_data_r(bus_rd),
		.pins_r(pins_r),
		.dq_in(dq_in)
	);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= S_IDLE;
			op_r <= '{op: fws_pkg::OP_PROGRAM, addr: 20'h00000, data: 8'h00};
			pend_r <= 1'b0;
			req_valid_r <= 1'b0;
			req_write_r <= 1'b0;
			req_data_r <= 8'h00;
			cnt_r <= 8'h00;
			cmd_ready_r <= 1'b1;
			done_r <= 1'b0;
			abort_r <= 1'b0;
			status_r <= 8'h00;
			err_acc_r <= 3'b000;
			rd_data_r <= 8'h00;
			pwd_n_r <= 1'b1;
		end else if (clk_en) begin
			done_r <= 1'b0;
			req_valid_r <= 1'b0;
			if (issue_go) begin
				req_valid_r <= 1'b1;
				req_write_r <= cyc_w[8];
				req_data_r <= cyc_w[7:0];
				pend_r <= 1'b1;
			end
			if (bus_done) begin
				pend_r <= 1'b0;
			end
			if (pd_hit) begin
				// powerdown aborts any sequence; user must repeat it
				state_r <= S_PD;
				pwd_n_r <= 1'b0;
				pend_r <= 1'b0;
				req_valid_r <= 1'b0;
				cmd_ready_r <= 1'b0;
				if (state_r != S_IDLE) begin
					abort_r <= 1'b1;
					done_r <= 1'b1;
				end
			end else begin
				unique case (state_r)
					S_IDLE: begin
						if (cmd_valid) begin
							op_r <= cmd_req;
							cmd_ready_r <= 1'b0;
							abort_r <= 1'b0;
							unique case (cmd_req.op)
								fws_pkg::OP_PROGRAM, fws_pkg::OP_ERASE: state_r <= S_CMD1;
								fws_pkg::OP_READ: state_r <= S_READ;
								fws_pkg::OP_CLEAR: state_r <= S_CLR;
							endcase
						end
					end
					S_CMD1: begin
						if (bus_done) begin
							state_r <= S_CMD2;
						end
					end
					S_CMD2: begin
						if (bus_done) begin
							cnt_r <= 8'(RFALL_CYC);
							state_r <= S_WAIT;
						end
					end
					S_WAIT: begin
						if (cnt_r == 8'h00) begin
							state_r <= S_POLL;
						end else begin
							cnt_r <= cnt_r - 8'h01;
						end
					end
					S_POLL: begin
						// each poll is a fresh read cycle, so oe_n rises between reads
						if (bus_done) begin
							status_r <= stat_w;
							if (stat_ready) begin
								state_r <= S_CHECK;
							end
						end
					end
					S_CHECK: begin
						// errors accumulate until the user clears them
						err_acc_r <= err_acc_r | stat_err;
						state_r <= (stat_err != 3'b000) ? S_CLR : S_ARRAY;
					end
					S_CLR: begin
						if (bus_done) begin
							if (op_r.op == fws_pkg::OP_CLEAR) begin
								err_acc_r <= 3'b000;
								status_r <= 8'h00;
							end
							state_r <= S_ARRAY;
						end
					end
					S_ARRAY: begin
						if (bus_done) begin
							done_r <= 1'b1;
							cmd_ready_r <= 1'b1;
							state_r <= S_IDLE;
						end
					end
					S_READ: begin
						if (bus_done) begin
							rd_data_r <= bus_rd;
							done_r <= 1'b1;
							cmd_ready_r <= 1'b1;
							state_r <= S_IDLE;
						end
					end
					S_PD: begin
						if (!pd_req) begin
							pwd_n_r <= 1'b1;
							cnt_r <= 8'(WAKE_CYC);
							state_r <= S_WAKE;
						end
					end
					S_WAKE: begin
						// device comes back in array-read mode, no read-array write needed
						if (cnt_r == 8'h00) begin
							cmd_ready_r <= 1'b1;
							state_r <= S_IDLE;
						end else begin
							cnt_r <= cnt_r - 8'h01;
						end
					end
					default: state_r <= S_IDLE;
				endcase
			end
		end
	end

	chk_prog_setup_code: assert property (@(posedge core_clk) disable iff (!reset_n)
		req_valid_r && state_r == S_CMD1 && op_r.op == fws_pkg::OP_PROGRAM |-> req_write_r && req_data_r == 8'h40)
		else $error("program setup code wrong");
	chk_prog_data_addr: assert property (@(posedge core_clk) disable iff (!reset_n)
		req_valid_r && state_r == S_CMD2 && op_r.op == fws_pkg::OP_PROGRAM |-> req_data_r == op_r.data ##1
		(pins_r.addr == op_r.addr)[*2])
		else $error("program data cycle wrong");
	chk_erase_codes: assert property (@(posedge core_clk) disable iff (!reset_n)
		req_valid_r && op_r.op == fws_pkg::OP_ERASE && (state_r == S_CMD1 || state_r == S_CMD2) |->
		req_data_r == ((state_r == S_CMD1) ? 8'h20 : 8'hD0))
		else $error("erase code wrong");
	chk_clear_code: assert property (@(posedge core_clk) disable iff (!reset_n)
		req_valid_r && state_r == S_CLR |-> req_write_r && req_data_r == 8'h50)
		else $error("clear-status code wrong");
	chk_array_before_done: assert property (@(posedge core_clk) disable iff (!reset_n)
		$rose(done_r) && is_prog_erase && !abort_r |-> $past(state_r) == S_ARRAY && $past(req_data_r) == 8'hFF)
		else $error("program or erase finished without read-array write");
	chk_supply_low_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
		clk_en && !pd_req && state_r == S_CHECK && status_r[`FWS_SR_SUPPLY_LOW] |=> state_r == S_CLR)
		else $error("supply-low not cleared before retry");
	chk_poll_toggle: assert property (@(posedge core_clk) disable iff (!reset_n)
		clk_en && !pd_req && state_r == S_POLL && bus_done && !stat_ready |-> pins_r.oe_n ##1
		(state_r == S_POLL && pins_r.oe_n) ##1 pins_r.oe_n)
		else $error("status polls not separated by oe_n high");
	chk_powerdown_abort: assert property (@(posedge core_clk) disable iff (!reset_n)
		clk_en && pd_hit && state_r != S_IDLE |=> !pwd_n_r && abort_r && done_r && state_r == S_PD)
		else $error("powerdown did not abort sequence");
	chk_err_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
		$fell(|err_acc_r) |-> $past(state_r) == S_CLR && op_r.op == fws_pkg::OP_CLEAR)
		else $error("accumulated error dropped without clear");
endmodule

// ==== fws_params.svh ====
// Purpose: constants for the flash write/erase sequencing controller
// Assumes: core_clk at 25 MHz
// Notes: times in ns, cycle counts derived from them
`ifndef FWS_PARAMS_SVH
`define FWS_PARAMS_SVH

`define FWS_CMD_PROG 8'h40
`define FWS_CMD_ERASE 8'h20
`define FWS_CMD_CONFIRM 8'hD0
`define FWS_CMD_CLEAR 8'h50
`define FWS_CMD_ARRAY 8'hFF

`define FWS_SR_READY 7
`define FWS_SR_ERASE_FAIL 5
`define FWS_SR_PROG_FAIL 4
`define FWS_SR_SUPPLY_LOW 3
`define FWS_STAT_MASK 8'hF8

`define FWS_CLK_NS 40
`define FWS_T_STROBE_NS 120
`define FWS_STROBE_CYC ((`FWS_T_STROBE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_T_RFALL_NS 200
`define FWS_RFALL_CYC ((`FWS_T_RFALL_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_T_WAKE_NS 1000
`define FWS_WAKE_CYC ((`FWS_T_WAKE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)

`endif

// ==== fws_pkg.sv ====
// Purpose: types for the flash write/erase sequencing controller
// Assumes: nothing
// Notes: pin group and user request travel as packed structs
package fws_pkg;
	typedef enum logic [1:0] {
		OP_PROGRAM = 2'b00,
		OP_ERASE = 2'b01,
		OP_READ = 2'b10,
		OP_CLEAR = 2'b11
	} fws_op_e;

	typedef struct packed {
		fws_op_e op;
		logic [19:0] addr;
		logic [7:0] data;
	} fws_req_s;

	typedef struct packed {
		logic [19:0] addr;
		logic [7:0] dq_out;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
	} fws_pins_s;
endpackage

// ==== fws_bus_cycle.sv ====
// Purpose: one read or write cycle on the flash pins
// Assumes: request pulse only while idle_r is high
// Notes: strobes return high after each cycle, so reads toggle oe_n
`timescale 1ns/10ps
`include "fws_params.svh"
module fws_bus_cycle #(
	parameter int STROBE_CYC = `FWS_STROBE_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [19:0] req_addr,
	input wire logic [7:0] req_data,
	input wire logic abort,
	// answer
	output logic idle_r,
	output logic done_r,
	output logic [7:0] rd_data_r,
	// flash pins
	output fws_pkg::fws_pins_s pins_r,
	input wire logic [7:0] dq_in
);
	typedef enum logic [1:0] {
		B_IDLE = 2'b00,
		B_SETUP = 2'b01,
		B_STROBE = 2'b10,
		B_HOLD = 2'b11
	} fws_bstate_e;

	fws_bstate_e state_r;
	logic [7:0] cnt_r;
	logic wr_r;
	wire cnt_zero = (cnt_r == 8'h00);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= B_IDLE;
			cnt_r <= 8'h00;
			wr_r <= 1'b0;
			idle_r <= 1'b1;
			done_r <= 1'b0;
			rd_data_r <= 8'h00;
			pins_r <= '{addr: 20'h00000, dq_out: 8'h00, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
		end else if (clk_en) begin
			done_r <= 1'b0;
			if (abort) begin
				state_r <= B_IDLE;
				idle_r <= 1'b1;
				pins_r.dq_oe <= 1'b0;
				pins_r.ce_n <= 1'b1;
				pins_r.oe_n <= 1'b1;
				pins_r.we_n <= 1'b1;
			end else begin
				unique case (state_r)
					B_IDLE: begin
						if (req_valid) begin
							wr_r <= req_write;
							pins_r.addr <= req_addr;
							pins_r.dq_out <= req_data;
							pins_r.dq_oe <= req_write;
							pins_r.ce_n <= 1'b0;
							idle_r <= 1'b0;
							state_r <= B_SETUP;
						end
					end
					B_SETUP: begin
						pins_r.we_n <= !wr_r;
						pins_r.oe_n <= wr_r;
						cnt_r <= 8'(STROBE_CYC - 1);
						state_r <= B_STROBE;
					end
					B_STROBE: begin
						if (cnt_zero) begin
							// write data latched by the device on this rising edge of we_n
							pins_r.we_n <= 1'b1;
							pins_r.oe_n <= 1'b1;
							if (!wr_r) begin
								rd_data_r <= dq_in;
							end
							state_r <= B_HOLD;
						end else begin
							cnt_r <= cnt_r - 8'h01;
						end
					end
					B_HOLD: begin
						pins_r.ce_n <= 1'b1;
						pins_r.dq_oe <= 1'b0;
						done_r <= 1'b1;
						idle_r <= 1'b1;
						state_r <= B_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// ==== fws_flash_model.sv ====
// Purpose: behavioural flash device on the far side of the controller pins
// Assumes: pins change just after core_clk edges
// Notes: busy length and faults are set by the bench
`timescale 1ns/10ps
module fws_flash_model (
	// clock
	input wire logic core_clk,
	// flash pins
	input fws_pkg::fws_pins_s pins,
	input wire logic pwd_n,
	output logic [7:0] dq,
	output logic ready_busy,
	// fault and busy-length control
	input wire logic fail_op,
	input wire logic supply_low,
	input wire logic [15:0] busy_cyc
);
	logic [7:0] mem [0:1048575];
	logic [2:0] flags_r = 3'b000;
	logic [15:0] busy_r = 16'h0000;
	logic [7:0] pend_r = 8'h00;
	logic [7:0] seen_r = 8'h80;
	logic [7:0] noise_r = 8'h00;
	logic status_mode_r = 1'b0;
	logic we_prev_r = 1'b1;
	wire [7:0] stat = {busy_r == 16'h0000, 1'b0, flags_r, 3'b000};
	wire we_rise = pins.we_n && !we_prev_r && !pins.ce_n;
	wire refuse = supply_low || flags_r[0];
	assign ready_busy = (busy_r == 16'h0000) || !pwd_n;
	assign dq = (!pins.ce_n && !pins.oe_n && pwd_n) ? (status_mode_r ? seen_r : mem[pins.addr]) : noise_r;
	initial for (int i = 0; i < 1048576; i++) mem[i] = 8'hFF;
	always @(negedge pins.oe_n or negedge pins.ce_n) seen_r <= stat;
	always @(posedge core_clk) begin
		we_prev_r <= pins.we_n;
		noise_r <= noise_r + 8'h3B;
		if (!pwd_n) begin
			flags_r <= 3'b000;
			busy_r <= 16'h0000;
			pend_r <= 8'h00;
			status_mode_r <= 1'b0;
		end else begin
			if (busy_r != 16'h0000)
				busy_r <= busy_r - 16'h0001;
			if (we_rise) begin
				pend_r <= 8'h00;
				status_mode_r <= 1'b1;
				if (pend_r == 8'h40 || pend_r == 8'h10) begin
					if (refuse)
						flags_r[0] <= 1'b1;
					else if (fail_op)
						flags_r[1] <= 1'b1;
					else
						mem[pins.addr] <= mem[pins.addr] & pins.dq_out;
					if (!refuse)
						busy_r <= busy_cyc;
				end else if (pend_r == 8'h20) begin
					if (pins.dq_out != 8'hD0)
						flags_r[2:1] <= 2'b11;
					else if (refuse)
						flags_r[0] <= 1'b1;
					else if (fail_op)
						flags_r[2] <= 1'b1;
					else
						for (int i = 0; i < 65536; i++) mem[{pins.addr[19:16], 16'(i)}] <= 8'hFF;
					if (pins.dq_out == 8'hD0 && !refuse)
						busy_r <= busy_cyc;
				end else if (pins.dq_out == 8'h50)
					flags_r <= 3'b000;
				else if (pins.dq_out == 8'hFF)
					status_mode_r <= 1'b0;
				else if (pins.dq_out inside {8'h40, 8'h10, 8'h20})
					pend_r <= pins.dq_out;
			end
		end
	end
endmodule

// ==== fws_ctrl_tb.sv ====
// Purpose: self-checking bench for the flash write/erase controller
// Assumes: flash model on the pins, seed fixed
// Notes: random program/erase with faults, then powerdown abort
`timescale 1ns/10ps
module fws_ctrl_tb;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic cmd_valid = 1'b0;
	logic pd_req = 1'b0;
	logic fail_op = 1'b0;
	logic supply_low = 1'b0;
	logic [15:0] busy_cyc = 16'h0004;
	fws_pkg::fws_req_s cmd_req = '0;
	fws_pkg::fws_pins_s pins;
	fws_pkg::fws_op_e op;
	logic cmd_ready_r, done_r, abort_r, pwd_n_r, ready_busy;
	logic [7:0] status_r, rd_data_r, dq, d;
	logic [2:0] err_acc_r, acc, e;
	logic [19:0] a;
	logic [7:0] img [0:1048575];
	int seed = 38;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	always #20 core_clk = ~core_clk;
	fws_ctrl #(.WAKE_CYC(3)) dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
		.cmd_valid(cmd_valid), .cmd_req(cmd_req), .cmd_ready_r(cmd_ready_r), .done_r(done_r),
		.abort_r(abort_r), .status_r(status_r), .err_acc_r(err_acc_r), .rd_data_r(rd_data_r),
		.pd_req(pd_req), .pins_r(pins), .dq_in(dq), .ready_busy_in(ready_busy), .pwd_n_r(pwd_n_r));
	fws_flash_model flash (.core_clk(core_clk), .pins(pins), .pwd_n(pwd_n_r), .dq(dq),
		.ready_busy(ready_busy), .fail_op(fail_op), .supply_low(supply_low), .busy_cyc(busy_cyc));
	function automatic logic [2:0] err_of(input fws_pkg::fws_op_e o, input logic f, input logic s);
		return s ? 3'b001 : (f ? ((o == fws_pkg::OP_ERASE) ? 3'b100 : 3'b010) : 3'b000);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		if (mismatches == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic issue(input fws_pkg::fws_op_e o, input logic [19:0] ad, input logic [7:0] da);
		while (cmd_ready_r !== 1'b1) @(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_req <= '{o, ad, da};
		do @(posedge core_clk); while (clk_en !== 1'b1);
		cmd_valid <= 1'b0;
	endtask
	task automatic wait_done;
		do @(posedge core_clk); while (done_r !== 1'b1);
	endtask
	task automatic apply(input fws_pkg::fws_op_e o);
		if (o == fws_pkg::OP_ERASE)
			for (int j = 0; j < 65536; j++) img[{a[19:16], 16'(j)}] = 8'hFF;
		else
			img[a] = img[a] & d;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		clk_en <= ($random(seed) & 7) != 0;
		if (cycles == 60000) begin
			mismatches++;
			results();
		end
	end
	initial begin
		for (int j = 0; j < 1048576; j++) img[j] = 8'hFF;
		acc = 3'b000;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		check({cmd_ready_r, pwd_n_r, pins.ce_n, pins.we_n, status_r}, 12'hF00);
		for (int i = 0; i < 12; i++) begin
			a = $random(seed);
			d = $random(seed);
			op = (i % 3 == 2) ? fws_pkg::OP_ERASE : fws_pkg::OP_PROGRAM;
			e = err_of(op, i % 4 == 1, i == 6);
			fail_op <= (i % 4 == 1);
			supply_low <= (i == 6);
			busy_cyc <= 16'(($random(seed) & 31) + 1);
			issue(op, a, d);
			wait_done();
			if (e == 3'b000)
				apply(op);
			acc = acc | e;
			check(status_r, {2'b10, e, 3'b000});
			check(err_acc_r, acc);
			issue(fws_pkg::OP_READ, a, 8'h00);
			wait_done();
			check(rd_data_r, img[a]);
		end
		issue(fws_pkg::OP_CLEAR, a, 8'h00);
		wait_done();
		check({err_acc_r, status_r}, 11'h000);
		busy_cyc <= 16'd300;
		fail_op <= 1'b0;
		supply_low <= 1'b0;
		d = 8'h5A;
		issue(fws_pkg::OP_PROGRAM, a, d);
		while (ready_busy !== 1'b0) @(posedge core_clk);
		pd_req <= 1'b1;
		wait_done();
		check({abort_r, pwd_n_r}, 2'b10);
		repeat (2) @(posedge core_clk);
		check(ready_busy, 1'b1);
		check(flash.stat, 8'h80);
		pd_req <= 1'b0;
		busy_cyc <= 16'h0005;
		apply(fws_pkg::OP_PROGRAM);
		issue(fws_pkg::OP_PROGRAM, a, d);
		wait_done();
		check({abort_r, status_r}, 9'h080);
		issue(fws_pkg::OP_READ, a, 8'h00);
		wait_done();
		check(rd_data_r, img[a]);
		results();
	end
endmodule
